// File: hw/socr_serial_output_config_regs.v
`timescale 1ns/1ps
`include "socr_map.vh"
module socr_serial_output_config_regs (
  input wire sys_clk, // 200 MHz clock
  input wire sys_rst, // async power-on class reset
  input wire appRst, // application reset pulse, same domain
  input wire regWr, // byte write strobe
  input wire [7:0] regAddr, // byte address
  input wire [7:0] regWrData, // write byte
  output reg [7:0] regRdData, // read byte, registered
  input wire [1:0] inputProtocolMode, // input side SPI mode
  input wire alarmIn, // alarm indication
  input wire [15:0] convData, // conversion result
  input wire [3:0] frameFlags, // flags and settings already in the frame
  output reg generalOutputPin, // general output pin
  output reg secondPinOut, // second output pin data
  output reg secondPinOe, // second output pin enable
  output reg dualLane, // two lanes active
  output reg outCpol, // output clock polarity
  output reg outCpha, // output clock phase
  output reg srcSyncMode, // controller-clock protocol active
  output reg useInternalClk, // internal clock selected for output
  output reg [15:0] outWord, // selected output data value
  output reg parityOn, // parity bits appended
  output reg convParity, // even parity over conversion bits
  output reg frameParity, // even parity over frame
  output reg [31:0] dataOutCtl, // data output control register image
  output reg [1:0] outputMode // stored output mode
);
  wire [31:0] socQ;
  wire [31:0] docQ;
  wire [31:0] socW = `SOCR_SOC_WMASK;
  wire [31:0] socA = `SOCR_SOC_APPMASK;
  wire [31:0] docW = `SOCR_DOC_WMASK;
  wire [31:0] docA = `SOCR_DOC_APPMASK;
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : gLane
      // lane addresses held at the bus width so the compare is 8 bits on both sides
      localparam [7:0] SOC_ADDR = `SOCR_SOC_BASE + i;
      localparam [7:0] DOC_ADDR = `SOCR_DOC_BASE + i;
      socr_byte_reg uSoc (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .appRst(appRst),
        .wrEn(regWr && (regAddr == SOC_ADDR)),
        .wrData(regWrData),
        .wMask(socW[8*i+7:8*i]),
        .appMask(socA[8*i+7:8*i]),
        .q_ff(socQ[8*i+7:8*i])
      );
      socr_byte_reg uDoc (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .appRst(appRst),
        .wrEn(regWr && (regAddr == DOC_ADDR)),
        .wrData(regWrData),
        .wMask(docW[8*i+7:8*i]),
        .appMask(docA[8*i+7:8*i]),
        .q_ff(docQ[8*i+7:8*i])
      );
    end
  endgenerate
  wire [1:0] mode = socQ[`SOCR_MODE_HI:`SOCR_MODE_LO];
  wire [1:0] pin2 = socQ[`SOCR_PIN2_HI:`SOCR_PIN2_LO];
  wire general_output_pin = socQ[`SOCR_GPO_BIT];
  wire [2:0] dval = docQ[`SOCR_DVAL_HI:`SOCR_DVAL_LO];
  reg alarmMeta_ff;
  reg alarmSync_ff;
  reg [7:0] nxt_rd;
  reg [15:0] nxt_word;
  reg nxt_secondOut;
  // alarm comes from a pin outside this clock domain: two flops before any use
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarmMeta_ff <= 1'b0;
    end else begin
      alarmMeta_ff <= alarmIn;
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarmSync_ff <= 1'b0;
    end else begin
      alarmSync_ff <= alarmMeta_ff;
    end
  end
  always @* begin
    case (regAddr)
      8'h0c: nxt_rd = socQ[7:0];
      8'h0d: nxt_rd = socQ[15:8];
      8'h0e: nxt_rd = 8'h00;
      8'h0f: nxt_rd = 8'h00;
      8'h10: nxt_rd = docQ[7:0];
      8'h11: nxt_rd = docQ[15:8];
      default: nxt_rd = 8'h00;
    endcase
    case (dval)
      3'h4: nxt_word = 16'h0000;
      3'h5: nxt_word = 16'hffff;
      3'h6: nxt_word = 16'haaaa;
      3'h7: nxt_word = 16'hcccc;
      default: nxt_word = convData;
    endcase
    case (pin2)
      `SOCR_PIN2_ALARM: nxt_secondOut = alarmSync_ff;
      `SOCR_PIN2_GPO: nxt_secondOut = general_output_pin;
      default: nxt_secondOut = 1'b0;
    endcase
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= nxt_rd;
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      generalOutputPin <= 1'b0;
    end else begin
      generalOutputPin <= general_output_pin;
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      secondPinOut <= 1'b0;
    end else begin
      secondPinOut <= nxt_secondOut;
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      secondPinOe <= 1'b0;
    end else begin
      secondPinOe <= (pin2 != `SOCR_PIN2_TRI);
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dualLane <= 1'b0;
    end else begin
      dualLane <= (pin2 == `SOCR_PIN2_DUAL);
    end
  end
  // mode 10 is turned into 11 by the host; here it simply behaves as neither follow nor sync
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outCpol <= 1'b0;
    end else begin
      outCpol <= mode[1] ? 1'b0 : inputProtocolMode[1];
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outCpha <= 1'b0;
    end else begin
      outCpha <= mode[1] ? 1'b0 : inputProtocolMode[0];
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      srcSyncMode <= 1'b0;
    end else begin
      srcSyncMode <= (mode == 2'h3);
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      useInternalClk <= 1'b0;
    end else begin
      useInternalClk <= (mode == 2'h3) & socQ[`SOCR_SSYNC_BIT];
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outWord <= 16'h0000;
    end else begin
      outWord <= nxt_word;
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      parityOn <= 1'b0;
    end else begin
      parityOn <= docQ[`SOCR_PAR_BIT];
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      convParity <= 1'b0;
    end else begin
      convParity <= ^nxt_word;
    end
  end
  // frame parity leaves out the conversion parity bit itself
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frameParity <= 1'b0;
    end else begin
      frameParity <= (^nxt_word) ^ (^frameFlags);
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataOutCtl <= 32'h0000_0000;
    end else begin
      dataOutCtl <= docQ;
    end
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outputMode <= 2'h0;
    end else begin
      outputMode <= mode;
    end
  end
endmodule // socr_serial_output_config_regs

// File: hw/socr_map.vh
`ifndef SOCR_MAP_VH
`define SOCR_MAP_VH
`define SOCR_ADDR_W 8
`define SOCR_SOC_BASE 8'h0c
`define SOCR_DOC_BASE 8'h10
`define SOCR_SOC_WMASK 32'h0000_1343
`define SOCR_SOC_APPMASK 32'h0000_1300
`define SOCR_DOC_WMASK 32'h0000_7d0f
`define SOCR_DOC_APPMASK 32'h0000_7d07
`define SOCR_SOC_RESET 32'h0000_0000
`define SOCR_DOC_RESET 32'h0000_0000
`define SOCR_MODE_LO 0
`define SOCR_MODE_HI 1
`define SOCR_SSYNC_BIT 6
`define SOCR_PIN2_LO 8
`define SOCR_PIN2_HI 9
`define SOCR_GPO_BIT 12
`define SOCR_PAR_BIT 3
`define SOCR_DVAL_LO 0
`define SOCR_DVAL_HI 2
`define SOCR_PIN2_TRI 2'h0
`define SOCR_PIN2_ALARM 2'h1
`define SOCR_PIN2_GPO 2'h2
`define SOCR_PIN2_DUAL 2'h3
`endif

// File: hw/socr_byte_reg.v
`timescale 1ns/1ps
// one byte lane of a register with per-bit write mask and two reset classes
module socr_byte_reg (
  input wire sys_clk, // clock
  input wire sys_rst, // power-on class reset
  input wire appRst, // application reset, synchronous pulse
  input wire wrEn, // write this lane
  input wire [7:0] wrData, // write data
  input wire [7:0] wMask, // writable bits
  input wire [7:0] appMask, // bits cleared by application reset
  output reg [7:0] q_ff // stored value
);
  wire [7:0] nxt_q;
  assign nxt_q = appRst ? (q_ff & ~appMask) :
                 (wrEn ? ((wrData & wMask) | (q_ff & ~wMask)) : q_ff);
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_ff <= 8'h00;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule // socr_byte_reg

// File: bench/socr_host_model.sv
`timescale 1ns/1ps
module socr_host_model (
  input wire sys_clk, // clock
  output logic regWr, // write strobe
  output logic [7:0] regAddr, // byte address
  output logic [7:0] regWrData, // write byte
  input wire [7:0] regRdData // read byte
);
  initial begin
    regWr = 0;
    regAddr = 0;
    regWrData = 0;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regWr <= 1;
    regAddr <= a;
    regWrData <= (a == 8'h0c && d[1:0] == 2'h2) ? d | 8'h01 : d;
    @(negedge sys_clk);
    regWr <= 0;
    regWrData <= ~d;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    regAddr <= a;
    @(negedge sys_clk);
    d = regRdData;
  endtask
endmodule // socr_host_model

// File: bench/socr_regs_sva.sv
`timescale 1ns/1ps
module socr_regs_sva (input wire sys_clk, sys_rst, appRst, regWr, generalOutputPin, secondPinOe,
  dualLane, outCpol, outCpha, srcSyncMode, useInternalClk, input wire [7:0] regAddr, regWrData,
  regRdData, input wire [1:0] inputProtocolMode, outputMode);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_gpoWr;
    regWr && regAddr == 8'h0d && !appRst ##1 !appRst;
  endsequence
  a_upper_zero: assert property (regAddr inside {8'h0e, 8'h0f} |=> regRdData == 8'h00)
    else $error("upper bytes not zero");
  a_reserved_bits: assert property (regAddr == 8'h0d |=> (regRdData & 8'hec) == 8'h00)
    else $error("reserved bits set");
  a_gpo_write: assert property (s_gpoWr |=> generalOutputPin == $past(regWrData[4], 2))
    else $error("general output pin wrong");
  a_src_mode: assert property (srcSyncMode == (outputMode == 2'h3))
    else $error("sync mode mismatch");
  a_clk_only_sync: assert property (useInternalClk |-> srcSyncMode)
    else $error("clock source outside sync mode");
  a_dual_drive: assert property (dualLane |-> secondPinOe)
    else $error("second lane not driven");
  a_spi_follow: assert property (!outputMode[1] |-> {outCpol, outCpha} == $past(inputProtocolMode))
    else $error("spi mode not followed");
  a_app_reset: assert property (appRst && !regWr |=> ##1 $stable(outputMode) && !generalOutputPin)
    else $error("app reset class wrong");
endmodule // socr_regs_sva
bind socr_serial_output_config_regs socr_regs_sva u_sva (.sys_clk, .sys_rst, .appRst, .regWr,
  .generalOutputPin, .secondPinOe, .dualLane, .outCpol, .outCpha, .srcSyncMode, .useInternalClk,
  .regAddr, .regWrData, .regRdData, .inputProtocolMode, .outputMode);

// File: bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("ERROR %0t mismatch", $time); end end
module tb_top;
  logic sysClk = 0, sys_rst = 1, appRst = 0, alarmIn = 0;
  logic [1:0] inputProtocolMode = 0;
  logic [3:0] frameFlags = 4'h1;
  logic [15:0] pat [5] = '{16'h5a3c, 16'h0000, 16'hffff, 16'haaaa, 16'hcccc};
  logic [7:0] d;
  wire regWr, general_output_pin, sOut, sOe, dual, cpol, cpha, ss, ick, par, cpar, fpar;
  wire [7:0] regAddr, regWrData, rd;
  wire [15:0] outWord;
  wire [31:0] doc;
  wire [1:0] om;
  int errors = 0, n_compared = 0, cyc = 0;
  initial forever #2.5 sysClk = ~sysClk;
  always @(posedge sysClk) if (++cyc == 3000) begin errors++; test_done(); end
  socr_serial_output_config_regs u_dut (.sys_clk(sysClk), .sys_rst, .appRst, .regWr, .regAddr,
    .regWrData, .regRdData(rd), .inputProtocolMode, .alarmIn, .convData(pat[0]), .frameFlags,
    .generalOutputPin(general_output_pin), .secondPinOut(sOut), .secondPinOe(sOe), .dualLane(dual),
    .outCpol(cpol), .outCpha(cpha), .srcSyncMode(ss), .useInternalClk(ick), .outWord,
    .parityOn(par), .convParity(cpar), .frameParity(fpar), .dataOutCtl(doc), .outputMode(om));
  socr_host_model u_host (.sys_clk(sysClk), .regWr, .regAddr, .regWrData, .regRdData(rd));
  task test_done;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chkRd(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    `CHK(d, e)
  endtask
  task wrW(input logic [7:0] a, input logic [7:0] v);
    u_host.wr(a, v);
    @(negedge sysClk);
  endtask
  task t_pin2;
    for (int c = 0; c < 4; c++) begin
      wrW(8'h0d, 8'h10 | c);
      `CHK(dual, c == 3)
      `CHK(sOe, c != 0)
      if (c == 2) `CHK(sOut, 1'b1)
      if (c == 1) begin
        alarmIn = 1;
        repeat (3) @(negedge sysClk);
        `CHK(sOut, 1'b1)
        alarmIn = 0;
        repeat (3) @(negedge sysClk);
        `CHK(sOut, 1'b0)
      end
    end
    wrW(8'h0d, 8'hff);
    chkRd(8'h0d, 8'h13);
    wrW(8'h0e, 8'hff);
    chkRd(8'h0e, 8'h00);
  endtask
  task t_mode;
    wrW(8'h0c, 8'hff);
    chkRd(8'h0c, 8'h43);
    `CHK({ss, ick}, 2'b11)
    `CHK(om, 2'h3)
    wrW(8'h0c, 8'h40);
    for (int m = 0; m < 4; m++) begin
      inputProtocolMode = m;
      repeat (2) @(negedge sysClk);
      `CHK({cpol, cpha, ick}, {m[1:0], 1'b0})
    end
  endtask
  task t_doc;
    wrW(8'h11, 8'hff);
    chkRd(8'h11, 8'h7d);
    for (int v = 3; v < 8; v++) begin
      wrW(8'h10, 8'h08 | v);
      `CHK(outWord, pat[v - 3])
      `CHK({par, cpar, fpar}, {1'b1, ^pat[v - 3], ^{pat[v - 3], frameFlags}})
    end
    chkRd(8'h10, 8'h0f);
    `CHK(doc, 32'h0000_7d0f)
  endtask
  initial begin
    repeat (4) @(negedge sysClk);
    sys_rst = 0;
    chkRd(8'h0c, 8'h00);
    t_pin2();
    t_mode();
    t_doc();
    appRst = 1;
    @(negedge sysClk);
    appRst = 0;
    chkRd(8'h0c, 8'h40);
    chkRd(8'h0d, 8'h00);
    chkRd(8'h10, 8'h08);
    chkRd(8'h11, 8'h00);
    test_done();
  end
endmodule // tb_top
